//--- rtl/cosd_top.sv
// Sync and digital delay control of the clock output groups, APB slave
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module cosd_top import cosd_pkg::*; #(
	parameter int COARSE_W = 10,
	parameter int DIV_W    = 11
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              sync_pin,
	input  wire logic              serial_latch_enable,
	input  wire logic [3:0]        serial_word_index,
	output logic [3:0]             group_run,
	output logic                   group4_clock
);
	localparam int CNT_W = COARSE_W + 3;

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (COARSE_W < 10 || COARSE_W > 16) begin : g_bad_coarse
		$error("COARSE_W must lie between 10 and 16");
	end
	if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
		$error("DIV_W must lie between 2 and 16");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]          pin_sq;
		logic [1:0]          le_sq;
		logic                le_prev;
		logic [3:0]          word_s1;
		logic [3:0]          word_s2;
		logic                pol;
		logic                auto_en;
		logic [1:0]          qual_sel;
		logic                adly_sel;
		logic [3:0]          excl;
		logic [2:0]          ofspd;
		logic [COARSE_W-1:0] coarse;
		logic [COARSE_W-1:0] coarse_apl;
		logic                hs;
		logic [DIV_W-1:0]    div;
		logic                req;
		logic [3:0]          part;
		logic [3:0]          run;
		cosd_state_t         state;
		logic [CNT_W-1:0]    cnt;
		logic [DIV_W-1:0]    div_cnt;
		logic                g4_clk;
		logic [4:0]          auto_cnt;
		logic [1:0]          auto_hold;
		logic [3:0]          auto_mask;
		logic [31:0]         prdata;
		logic                pslverr;
	} cosd_regs_t;

	cosd_regs_t s_q;
	cosd_regs_t s_d;

	logic              req_now;
	logic              start_ev;
	logic              release_ev;
	logic              le_fall;
	logic              wr_en;
	logic              mapped;
	logic [3:0]        bank_mask;
	logic [3:0]        low_hit;
	logic [3:0]        rise_hit;
	logic [CNT_W-1:0]  cnt_next;
	logic [CNT_W-1:0]  g4_low_t;
	logic [CNT_W-1:0]  g4_rise_t;
	logic [11:0]       rel_delay;
	logic [31:0]       rd_mux;
	logic [7:0]        addr;

	assign addr   = paddr[COSD_ADDR_W-1:0];
	assign pready = 1'b1;
	assign mapped = (addr == COSD_CTRL_OFS) || (addr == COSD_GROUP_OFS)
		|| (addr == COSD_G4DLY_OFS) || (addr == COSD_G4DIV_OFS)
		|| (addr == COSD_STATUS_OFS);
	assign wr_en  = psel && penable && pwrite && mapped;

	// ----------------------------------------------------------------
	// Request sources
	// ----------------------------------------------------------------
	// RULE_06 RULE_07 pin against polarity
	assign req_now   = (s_q.pin_sq[1] != s_q.pol) || (s_q.auto_hold != 2'h0);
	assign bank_mask = (s_q.pin_sq[1] != s_q.pol) ? COSD_BANK_ALL : s_q.auto_mask;
	// RULE_11 RULE_13 registering edges
	assign start_ev   = req_now && !s_q.req;
	assign release_ev = !req_now && s_q.req;
	assign le_fall    = s_q.le_prev && !s_q.le_sq[1];

	// ----------------------------------------------------------------
	// Delay arithmetic
	// ----------------------------------------------------------------
	// RULE_17 half-cycle relative delay
	assign rel_delay = 12'(({s_q.coarse_apl, 1'b0}) - {11'h000, s_q.hs}
		- 12'(2 * COSD_DDLY_BASE));
	// RULE_18 one timing path for outputs 12 and 13
	assign g4_low_t = (s_q.div > DIV_W'(1)) ? CNT_W'(COSD_LOW_G4DIV_H)
		: CNT_W'(COSD_LOW_STD_H);
	// RULE_16 divided group 4 adds its delay
	assign g4_rise_t = (s_q.div > DIV_W'(1))
		? CNT_W'(COSD_RISE_G4DIV_H) + {s_q.coarse_apl, 1'b0} - CNT_W'(s_q.hs)
		: CNT_W'(COSD_RISE_STD_H);
	assign cnt_next = (&s_q.cnt) ? s_q.cnt : s_q.cnt + CNT_W'(2);

	// RULE_12 RULE_14 RULE_15 per-group thresholds
	always_comb begin
		for (int g = 0; g < 3; g++) begin
			low_hit[g]  = cnt_next >= CNT_W'(COSD_LOW_STD_H);
			rise_hit[g] = cnt_next >= (s_q.ofspd[g] ? CNT_W'(COSD_RISE_STD_H)
				: CNT_W'(COSD_RISE_STD_H + COSD_OFFSET_H));
		end
		low_hit[3]  = cnt_next >= g4_low_t;
		rise_hit[3] = cnt_next >= g4_rise_t;
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (addr)
			COSD_CTRL_OFS: begin
				rd_mux[COSD_CTRL_POL]        = s_q.pol;
				rd_mux[COSD_CTRL_AUTO]       = s_q.auto_en;
				rd_mux[COSD_CTRL_QUAL +: 2]  = s_q.qual_sel;
				rd_mux[COSD_CTRL_ADLY]       = s_q.adly_sel;
			end
			COSD_GROUP_OFS: begin
				rd_mux[COSD_GRP_EXCL +: 4]   = s_q.excl;
				rd_mux[COSD_GRP_OFSPD +: 3]  = s_q.ofspd;
			end
			COSD_G4DLY_OFS: begin
				rd_mux[COARSE_W-1:0]         = s_q.coarse;
				rd_mux[COSD_DLY_HS]          = s_q.hs;
			end
			COSD_G4DIV_OFS: begin
				rd_mux[DIV_W-1:0]            = s_q.div;
			end
			COSD_STATUS_OFS: begin
				rd_mux[3:0]                  = s_q.run;
				rd_mux[COSD_ST_PART +: 4]    = s_q.part;
				rd_mux[COSD_ST_STATE +: 6]   = s_q.state;
				rd_mux[COSD_ST_REQ]          = s_q.req;
				rd_mux[COSD_ST_G4CLK]        = s_q.g4_clk;
				rd_mux[COSD_ST_REL +: 12]    = rel_delay;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pin_sq  = {s_q.pin_sq[0], sync_pin};
		s_d.le_sq   = {s_q.le_sq[0], serial_latch_enable};
		s_d.le_prev = s_q.le_sq[1];
		s_d.word_s1 = serial_word_index;
		s_d.word_s2 = s_q.word_s1;
		s_d.req     = req_now;
		s_d.cnt     = cnt_next;

		// Bus reads answer in the access phase from a registered word
		if (psel && !penable) begin
			s_d.prdata  = rd_mux;
			s_d.pslverr = !mapped;
		end
		if (wr_en) begin
			case (addr)
				COSD_CTRL_OFS: begin
					// RULE_07 polarity write may raise a request
					s_d.pol      = pwdata[COSD_CTRL_POL];
					s_d.auto_en  = pwdata[COSD_CTRL_AUTO];
					s_d.qual_sel = pwdata[COSD_CTRL_QUAL +: 2];
					s_d.adly_sel = pwdata[COSD_CTRL_ADLY];
				end
				COSD_GROUP_OFS: begin
					s_d.excl  = pwdata[COSD_GRP_EXCL +: 4];
					s_d.ofspd = pwdata[COSD_GRP_OFSPD +: 3];
				end
				COSD_G4DLY_OFS: begin
					// RULE_02 stored only, applied at sync
					s_d.coarse = pwdata[COARSE_W-1:0];
					// RULE_03 half step acts at once
					s_d.hs     = pwdata[COSD_DLY_HS];
				end
				COSD_G4DIV_OFS: begin
					s_d.div = (pwdata[DIV_W-1:0] == '0) ? DIV_W'(1) : pwdata[DIV_W-1:0];
				end
				default: begin
					s_d.div = s_q.div;
				end
			endcase
		end

		// RULE_08 RULE_09 automatic request after latch enable falls
		if (s_q.auto_cnt == 5'h01) begin
			s_d.auto_hold = 2'(COSD_AUTO_HOLD_CYC);
		end else if (s_q.auto_hold != 2'h0) begin
			s_d.auto_hold = s_q.auto_hold - 2'h1;
		end
		if (s_q.auto_cnt != 5'h00) begin
			s_d.auto_cnt = s_q.auto_cnt - 5'h01;
		end
		if (le_fall && s_q.auto_en) begin
			if (s_q.word_s2 == 4'(COSD_WORD_B)) begin
				s_d.auto_cnt  = 5'(COSD_AUTO_DLY_CYC);
				s_d.auto_mask = COSD_BANK_B;
			end else if (s_q.word_s2 == 4'(COSD_WORD_AB)) begin
				s_d.auto_cnt  = 5'(COSD_AUTO_DLY_CYC);
				s_d.auto_mask = COSD_BANK_ALL;
			end
		end

		// RULE_18 shared group 4 divider, restarts with the outputs
		if (!s_q.run[3] || s_q.div_cnt >= s_q.div - DIV_W'(1)) begin
			s_d.div_cnt = '0;
		end else begin
			s_d.div_cnt = s_q.div_cnt + DIV_W'(1);
		end
		s_d.g4_clk = s_q.run[3] && ((s_q.div == DIV_W'(1))
			|| (s_d.div_cnt < (s_q.div >> 1)));

		case (s_q.state)
			COSD_IDLE: begin
				s_d.run = 4'hf;
			end
			COSD_HOLD: begin
				// RULE_04 RULE_12 participants fall and stay low
				s_d.run = s_q.run & ~(s_q.part & low_hit);
				// A short request still pulls every participant low first
				if (!req_now && &(~s_d.run | ~s_q.part)) begin
					s_d.state = COSD_RELEASE;
					s_d.cnt   = '0;
				end
			end
			COSD_RELEASE: begin
				// RULE_05 RULE_14 RULE_15 RULE_16 aligned rise
				s_d.run = s_q.run | (s_q.part & rise_hit);
				if (&(s_d.run | ~s_q.part)) begin
					s_d.state = COSD_IDLE;
				end
			end
			COSD_QWAIT: begin
				// RULE_21 output 12 qualifies on its falling edge
				if (!req_now) begin
					s_d.state = COSD_IDLE;
				end else if (s_q.g4_clk && !s_d.g4_clk) begin
					s_d.state = COSD_QDLY;
					s_d.cnt   = '0;
				end
			end
			COSD_QDLY: begin
				// RULE_23 one-shot starts after the qualification delay
				if (cnt_next >= CNT_W'(COSD_QUAL_DLY_H)) begin
					s_d.state = COSD_QPULSE;
					s_d.cnt   = '0;
					s_d.run   = s_q.run & ~s_q.part;
				end
			end
			COSD_QPULSE: begin
				if (cnt_next >= CNT_W'(COSD_QUAL_PULSE_H)) begin
					s_d.state = COSD_IDLE;
					s_d.run   = 4'hf;
				end
			end
			default: begin
				s_d.state = COSD_IDLE;
			end
		endcase

		// RULE_11 RULE_19 RULE_20 start latches delay and participants
		if (start_ev) begin
			// RULE_01 excluded groups never take part
			s_d.part       = ~s_q.excl & bank_mask;
			// RULE_02 coarse delay applied here
			s_d.coarse_apl = s_q.coarse;
			s_d.cnt        = '0;
			s_d.state      = (s_q.qual_sel == 2'(COSD_QUAL_SEL_ON)) ? COSD_QWAIT : COSD_HOLD;
			if (s_q.state == COSD_RELEASE || s_q.state == COSD_HOLD) begin
				s_d.run = s_q.run;
			end else begin
				s_d.run = 4'hf;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q            <= '0;
			s_q.pol        <= 1'b0;
			s_q.ofspd      <= COSD_OFSPD_RST;
			s_q.coarse     <= COARSE_W'(COSD_COARSE_RST);
			s_q.coarse_apl <= COARSE_W'(COSD_COARSE_RST);
			s_q.div        <= DIV_W'(COSD_DIV_RST);
			s_q.run        <= 4'hf;
			s_q.state      <= COSD_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata       = s_q.prdata;
	assign pslverr      = s_q.pslverr;
	assign group_run    = s_q.run;
	assign group4_clock = s_q.g4_clk;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_exclude_running: assert property ( // RULE_01
		!s_q.part[0] |-> s_q.run[0]) else $error("Excluded group stopped");
	chk_coarse_apply: assert property ( // RULE_02
		$changed(s_q.coarse_apl) |-> $past(start_ev)) else $error("Coarse applied without sync");
	chk_halfstep_live: assert property ( // RULE_03
		$changed(s_q.hs) && $stable(s_q.coarse_apl) |-> $changed(rel_delay))
		else $error("Half step not live");
	chk_hold_low: assert property ( // RULE_04
		s_q.state == COSD_HOLD && s_q.part[0] && s_q.cnt >= CNT_W'(COSD_RISE_STD_H)
		|-> !s_q.run[0]) else $error("Held output not low");
	chk_start_edge: assert property ( // RULE_11
		start_ev |=> s_q.state == COSD_HOLD || s_q.state == COSD_QWAIT)
		else $error("Sync not started on first edge");
	chk_low_timing: assert property ( // RULE_12
		start_ev && s_q.state == COSD_IDLE && !s_q.excl[0] && bank_mask[0]
		&& s_q.qual_sel != 2'(COSD_QUAL_SEL_ON)
		##1 (s_q.state == COSD_HOLD) [*5] |=> !s_q.run[0]) else $error("Low time wrong");
	chk_rise_timing: assert property ( // RULE_14
		s_q.state == COSD_HOLD ##1 (s_q.state == COSD_RELEASE
		&& s_q.part[0] && s_q.ofspd[0] && !req_now) ##1 !req_now [*4]
		|=> s_q.run[0] && !$past(s_q.run[0], 1))
		else $error("Rise time wrong");
	chk_auto_delay: assert property ( // RULE_09
		le_fall && s_q.auto_en && s_q.word_s2 == 4'(COSD_WORD_AB) && s_q.auto_cnt == 5'h00
		&& s_q.auto_hold == 2'h0 |-> ##18 s_q.auto_hold != 2'h0)
		else $error("Auto sync delay wrong");
	chk_qual_pulse: assert property ( // RULE_23
		s_q.state == COSD_QDLY ##1 s_q.state == COSD_QPULSE |-> ##3 s_q.state == COSD_IDLE)
		else $error("Qualified pulse width wrong");

	cov_sync_cycle: cover property (start_ev ##[1:100] release_ev);
	cov_auto_sync: cover property (s_q.auto_hold != 2'h0 && start_ev);
	cov_qual_pulse: cover property (s_q.state == COSD_QPULSE);
endmodule // cosd_top
`default_nettype wire

//--- rtl/cosd_pkg.sv
// Constants, register map and types of the clock output sync and delay block
// Behaviour
// RULE_01: A group with its exclusion bit set ignores sync and keeps running.
// RULE_02: New group-4 coarse delay is applied only at a sync event.
// RULE_03: Group-4 half-step bit changes the delay at once, no sync needed.
// RULE_04: While sync is requested, participating outputs are held low.
// RULE_05: On release, participating outputs rise together, offset only by programmed delays.
// RULE_06: Outputs run when sync pin equals polarity bit, held low when they differ.
// RULE_07: Toggling the polarity bit by a register write requests a sync.
// RULE_08: Auto sync: word four write syncs bank B, word five syncs both banks.
// RULE_09: Auto sync is registered 170 ns after latch enable falls.
// RULE_10: The requester holds a sync request longer than one clock cycle.
// RULE_11: Sync begins on the first rising clock edge after the request asserts.
// RULE_12: Outputs 0-11 go low 4.5 cycles later; group 4 5.5 when divided.
// RULE_13: Release is registered on the first rising edge after deassertion.
// RULE_14: Outputs 0-11 rise 5 cycles after release; group 4 too if undivided.
// RULE_15: Fixed offset power-down clear adds 5 more cycles for that group.
// RULE_16: Divided group 4 rises 6 cycles after release plus its digital delay.
// RULE_17: Relative delay equals coarse minus 5, minus a half when half-step set.
// RULE_18: Outputs 12 and 13 share one divider and one delay path.
// RULE_19: Later syncs resync non-excluded groups with current delays only.
// RULE_20: Qualification select 3 qualifies sync by an output clock transition.
// RULE_21: Only output 12 may serve as the qualifying clock.
// RULE_22: Host keeps bank B input clock stable before sync when divided.
// RULE_23: Qualified mode fires a 3-cycle off pulse 1.5 cycles after qualification.
// RULE_24: Host holds half-step equal to divide oddness during qualified sync.
package cosd_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] COSD_CTRL_OFS   = 8'h00;
	localparam logic [7:0] COSD_GROUP_OFS  = 8'h04;
	localparam logic [7:0] COSD_G4DLY_OFS  = 8'h08;
	localparam logic [7:0] COSD_G4DIV_OFS  = 8'h0c;
	localparam logic [7:0] COSD_STATUS_OFS = 8'h10;
	localparam int COSD_ADDR_W = 8;

	// Field positions
	localparam int COSD_CTRL_POL   = 0;
	localparam int COSD_CTRL_AUTO  = 1;
	localparam int COSD_CTRL_QUAL  = 2;
	localparam int COSD_CTRL_ADLY  = 4;
	localparam int COSD_GRP_EXCL   = 0;
	localparam int COSD_GRP_OFSPD  = 4;
	localparam int COSD_DLY_HS     = 16;
	localparam int COSD_ST_PART    = 4;
	localparam int COSD_ST_STATE   = 8;
	localparam int COSD_ST_REQ     = 14;
	localparam int COSD_ST_G4CLK   = 15;
	localparam int COSD_ST_REL     = 16;

	// Reset values
	localparam logic [2:0] COSD_OFSPD_RST  = 3'h3;
	localparam int         COSD_COARSE_RST = 5;
	localparam int         COSD_DIV_RST    = 1;

	// ----------------------------------------------------------------
	// Timing, in half distribution cycles unless noted (COSD_DDLY_BASE in whole cycles), then select, word, bank and state codes
	// ----------------------------------------------------------------
	localparam int COSD_LOW_STD_H   = 9;
	localparam int COSD_LOW_G4DIV_H = 11;
	localparam int COSD_RISE_STD_H  = 10;
	localparam int COSD_OFFSET_H    = 10;
	localparam int COSD_RISE_G4DIV_H = 12;
	localparam int COSD_DDLY_BASE   = 5;
	localparam int COSD_QUAL_DLY_H  = 3;
	localparam int COSD_QUAL_PULSE_H = 6;
	localparam int COSD_QUAL_SEL_ON = 3;
	localparam int COSD_WORD_B      = 4;
	localparam int COSD_WORD_AB     = 5;

	localparam int COSD_CLK_PERIOD_NS = 10;
	localparam int COSD_AUTO_DLY_NS   = 170;
	localparam int COSD_AUTO_DLY_CYC  =
		(COSD_AUTO_DLY_NS + COSD_CLK_PERIOD_NS - 1) / COSD_CLK_PERIOD_NS;
	localparam int COSD_AUTO_HOLD_CYC = 2;

	localparam logic [3:0] COSD_BANK_B   = 4'hc;
	localparam logic [3:0] COSD_BANK_ALL = 4'hf;

	typedef enum logic [5:0] {
		COSD_IDLE    = 6'h01,
		COSD_HOLD    = 6'h02,
		COSD_RELEASE = 6'h04,
		COSD_QWAIT   = 6'h08,
		COSD_QDLY    = 6'h10,
		COSD_QPULSE  = 6'h20
	} cosd_state_t;
endpackage

//--- verif/cosd_host_model.sv
// Host side model driving the sync pin and the serial latch lines
`timescale 1ns/1ns
`default_nettype none
module cosd_host_model (
	input  wire logic       pclk,
	output logic            sync_pin,
	output logic            serial_latch_enable,
	output logic [3:0]      serial_word_index
);
	// ----------------------------------------------------------------
	// Idle levels
	// ----------------------------------------------------------------
	initial begin
		sync_pin = 1'b0;
		serial_latch_enable = 1'b0;
		serial_word_index = 4'h0;
	end

	// ----------------------------------------------------------------
	// Requests
	// ----------------------------------------------------------------
	task automatic set_pin(input logic v);
		@(posedge pclk);
		sync_pin <= v;
	endtask

	// long request, clock stable
	// Short pulses are stretched to four cycles, so no one cycle request goes unseen
	task automatic hold_sync(input int n);
		int k;
		k = (n < 4) ? 4 : n;
		set_pin(1'b1);
		repeat (k) @(posedge pclk);
		sync_pin <= 1'b0;
	endtask

	// Index stands around the latch fall, then turns to junk
	task automatic send_word(input logic [3:0] w);
		@(posedge pclk);
		serial_word_index <= w;
		serial_latch_enable <= 1'b1;
		repeat (3) @(posedge pclk);
		serial_latch_enable <= 1'b0;
		repeat (4) @(posedge pclk);
		serial_word_index <= ~w;
	endtask
endmodule // cosd_host_model
`default_nettype wire

//--- verif/cosd_top_test.sv
// Self-checking bench of the clock output sync and delay block
`timescale 1ns/1ns
`default_nettype none
module cosd_top_test import cosd_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite;
	logic        pready, pslverr, perr, sync_pin, sle, g4clk;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  swi, group_run, m;
	int          failures, comparisons;
	int          fall_at [4];
	int          rise_at [4];

	cosd_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .sync_pin(sync_pin),
		.serial_latch_enable(sle), .serial_word_index(swi),
		.group_run(group_run), .group4_clock(g4clk)
	);

	cosd_host_model u_host (
		.pclk(pclk), .sync_pin(sync_pin), .serial_latch_enable(sle),
		.serial_word_index(swi)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic st;
		apb(1'b0, COSD_STATUS_OFS, 32'h0);
		rd = {20'h0, rd[27:16]};
	endtask

	// Sampled on the falling edge, where outputs have settled
	task automatic watch(input int n);
		for (int g = 0; g < 4; g++) begin
			fall_at[g] = -1;
			rise_at[g] = -1;
		end
		for (int c = 0; c < n; c++) begin
			@(negedge pclk);
			for (int g = 0; g < 4; g++) begin
				if (group_run[g] === 1'b0 && fall_at[g] < 0)
					fall_at[g] = c;
				if (group_run[g] === 1'b1 && fall_at[g] >= 0 && rise_at[g] < 0)
					rise_at[g] = c;
			end
		end
	endtask

	task automatic fin(input string s);
		$display("test %s done", s);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, COSD_GROUP_OFS, 32'h0);
		chk(rd, 32'h30);
		apb(1'b0, COSD_G4DLY_OFS, 32'h0);
		chk(rd, 32'h5);
		wr(COSD_G4DIV_OFS, 32'h0);
		apb(1'b0, COSD_G4DIV_OFS, 32'h0);
		chk(rd, 32'h1);
		wr(8'h20, 32'h1);
		chk({31'h0, perr}, 32'h1);
		apb(1'b0, COSD_STATUS_OFS, 32'h0);
		chk(rd & 32'h0fff_7f0f, 32'h0000_010f);
		fin("regs");
	endtask

	task automatic t_pin;
		fork
			u_host.hold_sync(10);
			watch(50);
		join
		for (int g = 1; g < 4; g++)
			chk(fall_at[g], fall_at[0]);
		chk(rise_at[0] - fall_at[0], 10);
		chk(rise_at[1], rise_at[0]);
		chk(rise_at[3], rise_at[0]);
		chk(rise_at[2] - rise_at[0], 5);
		fin("pin");
	endtask

	task automatic t_pol;
		for (int v = 1; v >= 0; v--) begin
			fork
				begin
					wr(COSD_CTRL_OFS, v);
					repeat (10) @(posedge pclk);
					u_host.set_pin(v[0]);
				end
				watch(50);
			join
			chk(fall_at[0] >= 0, 1);
			chk(rise_at[3] > fall_at[3], 1);
		end
		fin("polarity");
	endtask

	task automatic t_excl;
		wr(COSD_GROUP_OFS, 32'h31);
		fork
			u_host.hold_sync(8);
			watch(50);
		join
		chk(fall_at[0], -1);
		chk(rise_at[1] > fall_at[1] && fall_at[1] >= 0, 1);
		wr(COSD_GROUP_OFS, 32'h30);
		fin("exclude");
	endtask

	task automatic t_delay;
		wr(COSD_G4DIV_OFS, 32'h2);
		wr(COSD_G4DLY_OFS, 32'hd);
		st();
		chk(rd, 32'h0);
		fork
			u_host.hold_sync(10);
			watch(60);
		join
		@(negedge pclk);
		m[0] = g4clk;
		@(negedge pclk);
		chk({31'h0, g4clk}, {31'h0, ~m[0]});
		chk(rise_at[3] - rise_at[0], 14);
		st();
		chk(rd, 32'h10);
		wr(COSD_G4DLY_OFS, 32'h0001_000d);
		st();
		chk(rd, 32'hf);
		wr(COSD_G4DLY_OFS, 32'hd);
		fin("delay");
	endtask

	task automatic t_qual;
		wr(COSD_CTRL_OFS, 32'hc);
		fork
			u_host.hold_sync(6);
			watch(50);
		join
		chk(rise_at[3] - fall_at[3], 3);
		chk(rise_at[0], rise_at[3]);
		wr(COSD_CTRL_OFS, 32'h0);
		fin("qualified");
	endtask

	task automatic t_auto;
		logic [3:0] w [3] = '{4'h3, 4'h4, 4'h5};
		logic [3:0] mk [3] = '{4'h0, 4'hc, 4'hf};
		wr(COSD_CTRL_OFS, 32'h2);
		foreach (w[i]) begin
			fork
				u_host.send_word(w[i]);
				watch(80);
			join
			for (int g = 0; g < 4; g++)
				m[g] = (fall_at[g] >= 0);
			chk({28'h0, m}, {28'h0, mk[i]});
			chk(m == 4'h0 || fall_at[3] >= 20, 1);
		end
		wr(COSD_CTRL_OFS, 32'h0);
		fin("auto");
	endtask

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		presetn = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_pin();
		t_pol();
		t_excl();
		t_delay();
		t_qual();
		t_auto();
		close_out();
	end

	// Tests need about 625 cycles; over nine times that is ample margin
	initial begin
		#60000;
		failures++;
		close_out();
	end
endmodule // cosd_top_test
`default_nettype wire
